/* hw/sp2_consts.vh */
// sp2_consts.vh: offsets, field positions and reset values of the
// second-profile configuration bank; assumes nothing beyond inclusion.
`ifndef SP2_CONSTS_VH
`define SP2_CONSTS_VH
// register indices; byte address is four times the index
`define SP2_IDX_REF_DIV 8'h15
`define SP2_IDX_LOOP_CFG 8'h16
`define SP2_IDX_PORT_CTRL 8'h17
`define SP2_IDX_MODE_TX 8'h18
// reset values
`define SP2_RST_REF_DIV 16'h0101
`define SP2_RST_LOOP_CFG 16'h8584
`define SP2_RST_PORT_CTRL 16'h10a4
`define SP2_RST_MODE_TX 16'h0010
// output port register fields
`define SP2_PORT_RXPWR_HI 12
`define SP2_PORT_RXPWR_LO 8
`define SP2_PORT_TXEN_BIT 7
`define SP2_PORT_RXEN_BIT 6
`define SP2_PORT_R4_HI 2
`define SP2_PORT_R4_LO 0
// loop/divider register fields
`define SP2_LOOP_R3_HI 15
`define SP2_LOOP_R3_LO 13
`define SP2_LOOP_DIV2_HI 12
`define SP2_LOOP_DIV2_LO 10
`define SP2_LOOP_DIV1_HI 9
`define SP2_LOOP_DIV1_LO 8
`define SP2_LOOP_PFD_HI 7
`define SP2_LOOP_PFD_LO 5
`define SP2_LOOP_MULT_HI 4
`define SP2_LOOP_MULT_LO 0
// reference divider fields
`define SP2_REF_POST_HI 15
`define SP2_REF_POST_LO 8
`define SP2_REF_PRE_HI 7
`define SP2_REF_PRE_LO 0
// mode / transmit level fields
`define SP2_MODE_EXT_BIT 5
`define SP2_MODE_TXPWR_HI 4
`define SP2_MODE_TXPWR_LO 0
// decode limits
`define SP2_DIV2_MAX_CODE 3'h6
`define SP2_MULT_MAX_CODE 5'h0d
`endif

/* hw/sp2_reg_word.v */
// sp2_reg_word.v: one 16-bit read/write configuration word.
// assumes a write strobe on clk_sys and an asynchronous high reset.
`timescale 1ns/1ns
module sp2_reg_word #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output reg [WIDTH-1:0] value
);
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end
endmodule

/* hw/sp2_config_regs.v */
// sp2_config_regs.v: second-profile configuration bank of a fractional-n
// synthesizer behind an ahb-lite slave, with decoded field outputs.
// assumes a single ahb-lite master, word transfers, hready from hreadyout.
`timescale 1ns/1ns
`include "sp2_consts.vh"

////////////////////////////////////////////////////////////////////////////
module sp2_config_regs #(
  parameter WIDTH = 16
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg [4:0] tx_port_power_level,
  output reg [4:0] rx_port_power_level,
  output reg tx_port_enable,
  output reg rx_port_enable,
  output reg [2:0] fourth_pole_resistor_sel,
  output reg [2:0] third_pole_resistor_sel,
  output reg [6:0] second_output_divider,
  output reg [2:0] first_output_divider,
  output reg [2:0] phase_detector_delay,
  output reg [3:0] reference_scaler_factor,
  output reg reference_scaler_reserved,
  output reg [7:0] reference_post_divider,
  output reg [7:0] reference_pre_divider,
  output reg external_oscillator_select
);

  ////////////////////////////////////////////////////////////////////////
  // address decode

  function [1:0] sp2_index;
    input [31:0] addr;
    begin
      case (addr[9:2])
        `SP2_IDX_REF_DIV: sp2_index = 2'd0;
        `SP2_IDX_LOOP_CFG: sp2_index = 2'd1;
        `SP2_IDX_PORT_CTRL: sp2_index = 2'd2;
        default: sp2_index = 2'd3;
      endcase
    end
  endfunction

  function sp2_hit;
    input [31:0] addr;
    begin
      sp2_hit = (addr[31:10] == 22'h0) && (addr[1:0] == 2'b00) &&
        ((addr[9:2] == `SP2_IDX_REF_DIV) ||
         (addr[9:2] == `SP2_IDX_LOOP_CFG) ||
         (addr[9:2] == `SP2_IDX_PORT_CTRL) ||
         (addr[9:2] == `SP2_IDX_MODE_TX));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay

  reg wr_pend;
  reg [1:0] wr_idx;
  wire addr_phase;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel && hready && htrans[1];

  // the write lands in the data phase; unmapped writes are dropped
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_idx <= 2'd0;
    end else begin
      wr_pend <= addr_phase && hwrite && sp2_hit(haddr);
      wr_idx <= sp2_index(haddr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register words

  wire [WIDTH-1:0] word [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_word
      // reserved bits are stored as written; software keeps them zero
      sp2_reg_word #(
        .WIDTH(WIDTH),
        .RESET_VALUE(g == 0 ? `SP2_RST_REF_DIV :
          g == 1 ? `SP2_RST_LOOP_CFG :
          g == 2 ? `SP2_RST_PORT_CTRL : `SP2_RST_MODE_TX)
      ) u_word (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_en(wr_pend && (wr_idx == g)),
        .wr_data(hwdata[WIDTH-1:0]),
        .value(word[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data: registered at the address phase, stands in the data phase

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      if (sp2_hit(haddr)) begin
        hrdata <= {16'h0, word[sp2_index(haddr)]};
      end else begin
        hrdata <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode, registered so outputs come from flip-flops

  wire [2:0] div2_code;
  wire [4:0] mult_code;
  assign div2_code = word[1][`SP2_LOOP_DIV2_HI:`SP2_LOOP_DIV2_LO];
  assign mult_code = word[1][`SP2_LOOP_MULT_HI:`SP2_LOOP_MULT_LO];

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_port_power_level <= 5'h10;
      rx_port_power_level <= 5'h10;
      tx_port_enable <= 1'b1;
      rx_port_enable <= 1'b0;
      fourth_pole_resistor_sel <= 3'h4;
      third_pole_resistor_sel <= 3'h4;
      second_output_divider <= 7'h02;
      first_output_divider <= 3'h5;
      phase_detector_delay <= 3'h4;
      reference_scaler_factor <= 4'h4;
      reference_scaler_reserved <= 1'b0;
      reference_post_divider <= 8'h01;
      reference_pre_divider <= 8'h01;
      external_oscillator_select <= 1'b0;
    end else begin
      tx_port_power_level <=
        word[3][`SP2_MODE_TXPWR_HI:`SP2_MODE_TXPWR_LO];
      rx_port_power_level <=
        word[2][`SP2_PORT_RXPWR_HI:`SP2_PORT_RXPWR_LO];
      tx_port_enable <= word[2][`SP2_PORT_TXEN_BIT];
      rx_port_enable <= word[2][`SP2_PORT_RXEN_BIT];
      // code 0 bypasses the pole, higher codes lower resistance
      fourth_pole_resistor_sel <=
        word[2][`SP2_PORT_R4_HI:`SP2_PORT_R4_LO];
      third_pole_resistor_sel <=
        word[1][`SP2_LOOP_R3_HI:`SP2_LOOP_R3_LO];
      // code 7 undefined; clamp to the largest ratio
      if (div2_code > `SP2_DIV2_MAX_CODE) begin
        second_output_divider <= 7'h40;
      end else begin
        second_output_divider <= 7'h01 << div2_code;
      end
      first_output_divider <= 3'h4 +
        {1'b0, word[1][`SP2_LOOP_DIV1_HI:`SP2_LOOP_DIV1_LO]};
      // limits depend on n-divider mode, not checked here
      phase_detector_delay <=
        word[1][`SP2_LOOP_PFD_HI:`SP2_LOOP_PFD_LO];
      // reserved codes flagged, factor forced to bypass
      if (mult_code == 5'h00 || mult_code > `SP2_MULT_MAX_CODE) begin
        reference_scaler_factor <= 4'h1;
        reference_scaler_reserved <= 1'b1;
      end else begin
        reference_scaler_factor <= mult_code[3:0];
        reference_scaler_reserved <= 1'b0;
      end
      reference_post_divider <=
        word[0][`SP2_REF_POST_HI:`SP2_REF_POST_LO];
      reference_pre_divider <=
        word[0][`SP2_REF_PRE_HI:`SP2_REF_PRE_LO];
      external_oscillator_select <= word[3][`SP2_MODE_EXT_BIT];
    end
  end

endmodule

/* tb/sp2_config_regs_monitor.sv */
// sp2_config_regs_monitor.sv: bus and field checks on the bank's ports.
// assumes one ahb-lite master and word transfers only.
`timescale 1ns/1ns
module sp2_config_regs_monitor #(
  parameter WIDTH = 16
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire tx_port_enable,
  input wire [6:0] second_output_divider,
  input wire [2:0] first_output_divider,
  input wire [3:0] reference_scaler_factor,
  input wire reference_scaler_reserved,
  input wire [7:0] reference_pre_divider,
  input wire external_oscillator_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire tk = hsel && hready && htrans[1];
  wire wr = tk && hwrite;
  wire hole = haddr != 32'h54 && haddr != 32'h58 &&
    haddr != 32'h5c && haddr != 32'h60;
  ////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (hreadyout) else $error("wait state");
  a_hole_reads_zero: assert property (tk && !hwrite && hole |=>
    hrdata == 32'h0) else $error("unmapped read");
  // fields lag the word by one clock, so three edges after the address
  a_tx_en_write:
    assert property (wr && haddr == 32'h5c ##1 1 |-> ##2
    tx_port_enable == $past(hwdata[7], 2)) else $error("tx enable");
  a_pre_div_write:
    assert property (wr && haddr == 32'h54 ##1 1 |-> ##2
    reference_pre_divider == $past(hwdata[7:0], 2)) else $error("pre");
  a_ext_sel_write:
    assert property (wr && haddr == 32'h60 ##1 1 |-> ##2
    external_oscillator_select == $past(hwdata[5], 2)) else $error("ext");
  a_div1_range:
    assert property (first_output_divider >= 3'h4) else $error("div1");
  a_div2_power:
    assert property ($onehot(second_output_divider)) else $error("div2");
  a_scaler_reserved:
    assert property (reference_scaler_reserved |->
    reference_scaler_factor == 4'h1) else $error("scaler");
  c_port_write: cover property (wr && haddr == 32'h5c);
  c_hole_read: cover property (tk && !hwrite && hole);
  c_reserved: cover property (reference_scaler_reserved);
endmodule

bind sp2_config_regs sp2_config_regs_monitor #(.WIDTH(WIDTH)) mon_u (
  .clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .tx_port_enable, .second_output_divider,
  .first_output_divider, .reference_scaler_factor,
  .reference_scaler_reserved, .reference_pre_divider,
  .external_oscillator_select);

/* tb/tb.sv */
// tb.sv: register and field tests for the second-profile bank.
// assumes the monitor is bound in; word-only ahb-lite access.
`timescale 1ns/1ns
module tb;
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp_w;
  wire [52:0] fld;
  reg [31:0] rd;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  reg [15:0] rst_tab [0:3] = '{16'h0101, 16'h8584, 16'h10a4, 16'h0010};
  reg [15:0] wr_tab [0:3] = '{16'ha503, 16'hfe2d, 16'h1f47, 16'h002b};
  always #2 clk_sys = ~clk_sys;
  sp2_config_regs dut_u (
    .clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(hresp_w),
    .tx_port_power_level(fld[52:48]), .rx_port_power_level(fld[47:43]),
    .tx_port_enable(fld[42]), .rx_port_enable(fld[41]),
    .fourth_pole_resistor_sel(fld[40:38]),
    .third_pole_resistor_sel(fld[37:35]),
    .second_output_divider(fld[34:28]), .first_output_divider(fld[27:25]),
    .phase_detector_delay(fld[24:22]), .reference_scaler_factor(fld[21:18]),
    .reference_scaler_reserved(fld[17]), .reference_post_divider(fld[16:9]),
    .reference_pre_divider(fld[8:1]), .external_oscillator_select(fld[0]));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] got, input [63:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one single transfer; hready is waited on, never counted
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
    end
  endtask
  task summarize;
    begin
      $display("compares %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    chk(fld, {5'h10, 5'h10, 2'h2, 3'h4, 3'h4, 7'h02, 3'h5, 3'h4, 4'h4,
      1'h0, 8'h01, 8'h01, 1'h0});
    sys_rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b0, 32'h54 + 4 * i, 32'h0);
      chk(rd, rst_tab[i]);
      chk(hresp_w, 1'b0);
    end
    // reserved bits written as zero
    for (i = 0; i < 4; i = i + 1)
      xfer(1'b1, 32'h54 + 4 * i, wr_tab[i]);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b0, 32'h54 + 4 * i, 32'h0);
      chk(rd, wr_tab[i]);
    end
    chk(fld, {5'h0b, 5'h1f, 2'h1, 3'h7, 3'h7, 7'h40, 3'h6, 3'h1, 4'hd,
      1'h0, 8'ha5, 8'h03, 1'h1});
    xfer(1'b1, 32'h58, 32'h000e);
    xfer(1'b0, 32'h64, 32'h0);
    chk(rd, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(fld[37:17], {3'h0, 7'h01, 3'h4, 3'h0, 4'h1, 1'h1});
    summarize;
  end
endmodule
